/* hdl/autoread_pkg.sv */
// shared constants for the serial memory auto-read engine
package autoread_pkg;
    localparam int unsigned MEM_BITS       = 1024;
    localparam int unsigned MEM_WORD_BITS  = 16;
    localparam int unsigned MEM_ADDR_BITS  = 6;
    localparam int unsigned CMD_BITS       = 9;
    localparam int unsigned FRAME_BITS     = 17;
    localparam int unsigned REG_ADDR_BITS  = 5;
    localparam int unsigned DAC_BITS       = 10;
    localparam int unsigned REG_COUNT      = 19;
    localparam logic [0:0] START_BIT       = 1'h1;
    localparam logic [1:0] READ_OPCODE     = 2'h2;
    localparam logic [5:0] ADDR_FIRST      = 6'h00;
    localparam logic [5:0] ADDR_LAST       = 6'h12;
    localparam logic [0:0] TEST_BIT        = 1'h0;
    localparam logic [3:0] CMD_LAST_BIT    = 4'h8;
    localparam logic [3:0] DATA_LAST_BIT   = 4'hF;
    localparam logic [4:0] FRAME_LAST_BIT  = 5'h10;
    localparam logic [4:0] FRAME_FULL      = 5'h11;
    localparam logic [9:0] GAMMA_RESET     = 10'h000;
    localparam logic [0:0] REFRESH_RESET   = 1'h0;
    localparam int unsigned WORD_REG_MSB   = 14;
endpackage : autoread_pkg

/* hdl/word_capture_sync.sv */
// core-side receiver of a word handed over by toggle handshake
`timescale 1ns/1ps
`default_nettype none
module word_capture_sync #(
    parameter int unsigned WIDTH = 16
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_arst_n,
    input  wire logic             i_req_toggle,
    input  wire logic [WIDTH-1:0] i_word,
    input  wire logic             i_accept,
    output logic      [WIDTH-1:0] o_word,
    output logic                  o_word_valid,
    output logic                  o_ack_toggle
);
    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("word width must be at least one bit");
        end
    endgenerate

    logic req_meta;
    logic req_sync;
    logic req_seen;
    wire  new_req = req_sync ^ req_seen;

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            req_meta     <= 1'b0;
            req_sync     <= 1'b0;
            req_seen     <= 1'b0;
            o_word       <= '0;
            o_word_valid <= 1'b0;
            o_ack_toggle <= 1'b0;
        end else begin
            req_meta <= i_req_toggle;
            req_sync <= req_meta;
            if (new_req && !o_word_valid) begin
                req_seen     <= req_sync;
                o_word       <= i_word;
                o_word_valid <= 1'b1;
            end else if (o_word_valid && i_accept) begin
                o_word_valid <= 1'b0;
                o_ack_toggle <= ~o_ack_toggle;
            end
        end
    end
endmodule : word_capture_sync
`default_nettype wire

/* hdl/gamma_frame_loader.sv */
// serial frame shift register and gamma register bank
`timescale 1ns/1ps
`default_nettype none
module gamma_frame_loader #(
    parameter int unsigned REGS = autoread_pkg::REG_COUNT,
    parameter int unsigned DACW = autoread_pkg::DAC_BITS
) (
    input  wire logic                 i_core_clk,
    input  wire logic                 i_arst_n,
    input  wire logic                 i_serial_frame_in,
    input  wire logic                 i_shift_pulse,
    input  wire logic                 i_load_strobe,
    output logic      [REGS*DACW-1:0] o_gamma_regs,
    output logic                      o_refresh_source_select
);
    generate
        if (REGS < 1 || REGS > 32 || DACW != autoread_pkg::DAC_BITS) begin : g_bad_size
            $error("register count or DAC width not supported");
        end
    endgenerate

    logic [autoread_pkg::FRAME_BITS-1:0] frame;
    logic [4:0]                          count;
    logic                                strobe_q;
    logic [DACW-1:0]                     regs [REGS];

    wire       strobe_rise = i_load_strobe && !strobe_q;
    wire       frame_ok    = strobe_rise && (count == autoread_pkg::FRAME_FULL);
    wire [4:0] frame_addr  = frame[DACW +: autoread_pkg::REG_ADDR_BITS];
    wire       addr_ok     = frame_addr < 5'(REGS);

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            frame    <= '0;
            count    <= '0;
            strobe_q <= 1'b1;
        end else begin
            strobe_q <= i_load_strobe;
            if (strobe_rise) begin
                count <= '0;
            end else if (!i_load_strobe && i_shift_pulse) begin
                frame <= {frame[autoread_pkg::FRAME_BITS-2:0], i_serial_frame_in};
                if (count != autoread_pkg::FRAME_FULL) begin
                    count <= count + 5'h01;
                end
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_refresh_source_select <= autoread_pkg::REFRESH_RESET;
        end else if (frame_ok) begin
            o_refresh_source_select <= frame[autoread_pkg::FRAME_BITS-2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    genvar g;
    generate
        for (g = 0; g < REGS; g++) begin : g_reg
            always_ff @(posedge i_core_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    regs[g] <= autoread_pkg::GAMMA_RESET;
                end else if (frame_ok && addr_ok && frame_addr == 5'(g)) begin
                    regs[g] <= frame[DACW-1:0];
                end
            end
            assign o_gamma_regs[g*DACW +: DACW] = regs[g];
        end
    endgenerate
endmodule : gamma_frame_loader
`default_nettype wire

/* hdl/serial_eeprom_autoread.sv */
// auto-read engine: fetches setting words and replays them as load frames
`timescale 1ns/1ps
`default_nettype none
// Contract
// - fetch configuration from external 1 kbit serial memory without host help
// - select and command outputs change only on serial clock falling edges
// - each fetch sends start bit, read opcode, then word address
// - returned word bits are sampled on serial clock falling edges
// - each captured word is replayed as serial data plus a load strobe
// - addresses run 00H up to 12H then wrap to 00H forever
// - while hold is low, reads follow one another without stopping
// - while hold is high, select and command outputs are released
// - word is MSB first; bits D14 to D0 become frame bits d2 to d16
// - frame: test zero, refresh source, five address bits, ten data bits
// - frame bits shift on rising edges; strobe rise loads last 17 bits
// - power-on reset clears interface, auto-read state and gamma registers
module serial_eeprom_autoread #(
    parameter int unsigned REGS = autoread_pkg::REG_COUNT
) (
    input  wire logic                                i_core_clk,
    input  wire logic                                i_arst_n,
    input  wire logic                                i_mem_clk,
    input  wire logic                                i_hold,
    input  wire logic                                i_mem_word_in,
    input  wire logic                                i_refresh_external,
    output logic                                     o_mem_select,
    output logic                                     o_mem_select_oe,
    output logic                                     o_mem_command_out,
    output logic                                     o_mem_command_oe,
    output logic [REGS*autoread_pkg::DAC_BITS-1:0]   o_gamma_regs,
    output logic                                     o_refresh_source_select
);
    generate
        if (REGS != int'(autoread_pkg::ADDR_LAST) + 1) begin : g_bad_regs
            $error("register count must match the fetched address range");
        end
    endgenerate

    typedef enum logic [1:0] {
        L_IDLE,
        L_COMMAND,
        L_DATA,
        L_HANDOFF
    } link_state_t;

    typedef enum logic [1:0] {
        F_IDLE,
        F_SHIFT,
        F_LATCH
    } frame_state_t;

    localparam int unsigned WB = autoread_pkg::MEM_WORD_BITS;
    localparam int unsigned AB = autoread_pkg::MEM_ADDR_BITS;
    localparam int unsigned CB = autoread_pkg::CMD_BITS;
    localparam int unsigned FB = autoread_pkg::FRAME_BITS;

    ////////////////////////////////////////////////////////////////////////////////
    // link domain: runs on the falling edge of the memory serial clock
    link_state_t    link_state;
    link_state_t    next_link_state;
    logic           hold_meta;
    logic           hold_sync;
    logic           ack_meta;
    logic           ack_sync;
    logic           req_toggle;
    logic           ack_toggle;
    logic [AB-1:0]  word_addr;
    logic [CB-1:0]  cmd_shift;
    logic [WB-1:0]  word_shift;
    logic [WB-1:0]  word_hold;
    logic [3:0]     bit_cnt;

    wire            hand_busy  = req_toggle ^ ack_sync;
    wire            fetch_go   = !hold_sync && !hand_busy;
    wire [CB-1:0]   read_cmd   = {autoread_pkg::START_BIT, autoread_pkg::READ_OPCODE,
                                  word_addr};
    wire            cmd_done   = bit_cnt == autoread_pkg::CMD_LAST_BIT;
    wire            data_done  = bit_cnt == autoread_pkg::DATA_LAST_BIT;
    wire            addr_wrap  = word_addr == autoread_pkg::ADDR_LAST;
    wire [AB-1:0]   next_addr  = addr_wrap ? autoread_pkg::ADDR_FIRST
                                           : word_addr + 6'h01;
    wire [WB-1:0]   next_word  = {word_shift[WB-2:0], i_mem_word_in};
    wire            fetch_start = link_state == L_IDLE && fetch_go;
    // a word read to its last bit is handed over even if hold rises
    wire            word_done  = (link_state == L_DATA && data_done) || link_state == L_HANDOFF;

    always_comb begin
        next_link_state = link_state;
        if (hold_sync && !word_done) begin
            next_link_state = L_IDLE;
        end else begin
            unique case (link_state)
                L_IDLE: begin
                    if (fetch_go) begin
                        next_link_state = L_COMMAND;
                    end
                end
                L_COMMAND: begin
                    if (cmd_done) begin
                        next_link_state = L_DATA;
                    end
                end
                L_DATA: begin
                    if (data_done) begin
                        next_link_state = L_HANDOFF;
                    end
                end
                L_HANDOFF: begin
                    next_link_state = L_IDLE;
                end
            endcase
        end
    end

    always_ff @(negedge i_mem_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            hold_meta <= 1'b1;
            hold_sync <= 1'b1;
            ack_meta  <= 1'b0;
            ack_sync  <= 1'b0;
        end else begin
            hold_meta <= i_hold;
            hold_sync <= hold_meta;
            ack_meta  <= ack_toggle;
            ack_sync  <= ack_meta;
        end
    end

    always_ff @(negedge i_mem_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            link_state <= L_IDLE;
        end else begin
            link_state <= next_link_state;
        end
    end

    // select: high from the start bit to the last data bit
    always_ff @(negedge i_mem_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_mem_select    <= 1'b0;
            o_mem_select_oe <= 1'b0;
        end else begin
            o_mem_select_oe <= !hold_sync;
            if (hold_sync) begin
                o_mem_select <= 1'b0;
            end else if (fetch_start) begin
                o_mem_select <= 1'b1;
            end else if (link_state == L_DATA && data_done) begin
                o_mem_select <= 1'b0;
            end
        end
    end

    // command: start bit, opcode, address, then low
    always_ff @(negedge i_mem_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_mem_command_out <= 1'b0;
            o_mem_command_oe  <= 1'b0;
        end else begin
            o_mem_command_oe <= !hold_sync;
            if (hold_sync) begin
                o_mem_command_out <= 1'b0;
            end else if (fetch_start) begin
                o_mem_command_out <= read_cmd[CB-1];
            end else if (link_state == L_COMMAND && !cmd_done) begin
                o_mem_command_out <= cmd_shift[CB-2];
            end else if (link_state == L_COMMAND) begin
                o_mem_command_out <= 1'b0;
            end
        end
    end

    always_ff @(negedge i_mem_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cmd_shift  <= '0;
            bit_cnt    <= '0;
            word_shift <= '0;
        end else begin
            if (link_state == L_IDLE) begin
                cmd_shift <= read_cmd;
                bit_cnt   <= '0;
            end else if (link_state == L_COMMAND) begin
                cmd_shift <= {cmd_shift[CB-2:0], 1'b0};
                bit_cnt   <= cmd_done ? 4'h0 : bit_cnt + 4'h1;
            end else if (link_state == L_DATA) begin
                word_shift <= next_word;
                bit_cnt    <= bit_cnt + 4'h1;
            end
        end
    end

    always_ff @(negedge i_mem_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            word_addr  <= autoread_pkg::ADDR_FIRST;
            word_hold  <= '0;
            req_toggle <= 1'b0;
        end else if (link_state == L_HANDOFF) begin
            word_addr  <= next_addr;
            word_hold  <= word_shift;
            req_toggle <= ~req_toggle;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // core domain: word arrival and frame replay
    logic [WB-1:0] core_word;
    logic          core_word_valid;
    logic          refresh_meta;
    logic          refresh_sync;
    frame_state_t  frame_state;
    logic [FB-1:0] frame_shift;
    logic [4:0]    frame_cnt;
    logic          serial_frame_in;
    logic          shift_pulse;
    logic          load_strobe;

    wire           frame_accept = frame_state == F_IDLE && core_word_valid;
    wire [FB-1:0]  frame_word   = {autoread_pkg::TEST_BIT, refresh_sync,
                                   core_word[autoread_pkg::WORD_REG_MSB:0]};
    wire           frame_end    = frame_cnt == autoread_pkg::FRAME_LAST_BIT;

    word_capture_sync #(
        .WIDTH (WB)
    ) u_capture (
        .i_core_clk   (i_core_clk),
        .i_arst_n     (i_arst_n),
        .i_req_toggle (req_toggle),
        .i_word       (word_hold),
        .i_accept     (frame_accept),
        .o_word       (core_word),
        .o_word_valid (core_word_valid),
        .o_ack_toggle (ack_toggle)
    );

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            refresh_meta <= 1'b0;
            refresh_sync <= 1'b0;
        end else begin
            refresh_meta <= i_refresh_external;
            refresh_sync <= refresh_meta;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            frame_state     <= F_IDLE;
            frame_shift     <= '0;
            frame_cnt       <= '0;
            serial_frame_in <= 1'b0;
            shift_pulse     <= 1'b0;
            load_strobe     <= 1'b1;
        end else begin
            unique case (frame_state)
                F_IDLE: begin
                    shift_pulse <= 1'b0;
                    if (frame_accept) begin
                        frame_shift <= frame_word;
                        frame_cnt   <= '0;
                        load_strobe <= 1'b0;
                        frame_state <= F_SHIFT;
                    end
                end
                F_SHIFT: begin
                    serial_frame_in <= frame_shift[FB-1];
                    shift_pulse     <= 1'b1;
                    frame_shift     <= {frame_shift[FB-2:0], 1'b0};
                    frame_cnt       <= frame_cnt + 5'h01;
                    if (frame_end) begin
                        frame_state <= F_LATCH;
                    end
                end
                F_LATCH: begin
                    shift_pulse <= 1'b0;
                    load_strobe <= 1'b1;
                    frame_state <= F_IDLE;
                end
                default: begin
                    frame_state <= F_IDLE;
                end
            endcase
        end
    end

    gamma_frame_loader #(
        .REGS (REGS),
        .DACW (autoread_pkg::DAC_BITS)
    ) u_loader (
        .i_core_clk              (i_core_clk),
        .i_arst_n                (i_arst_n),
        .i_serial_frame_in       (serial_frame_in),
        .i_shift_pulse           (shift_pulse),
        .i_load_strobe           (load_strobe),
        .o_gamma_regs            (o_gamma_regs),
        .o_refresh_source_select (o_refresh_source_select)
    );
endmodule : serial_eeprom_autoread
`default_nettype wire

/* tb/serial_eeprom_autoread_assertions.sv */
// port assertions for the serial memory auto-read engine
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_autoread_assertions #(
    parameter int unsigned REGS = autoread_pkg::REG_COUNT
) (
    input wire logic                                 i_core_clk,
    input wire logic                                 i_arst_n,
    input wire logic                                 i_mem_clk,
    input wire logic                                 i_hold,
    input wire logic                                 o_mem_select,
    input wire logic                                 o_mem_select_oe,
    input wire logic                                 o_mem_command_out,
    input wire logic                                 o_mem_command_oe,
    input wire logic [REGS*autoread_pkg::DAC_BITS-1:0] o_gamma_regs
);
    localparam int DW = autoread_pkg::DAC_BITS;
    logic      [3:0]         pins_at_rise;
    logic      [4:0]         sel_run;
    logic      [REGS*DW-1:0] regs_prev;
    logic      [REGS-1:0]    reg_changed;
    wire logic [3:0]         pins = {o_mem_select, o_mem_select_oe, o_mem_command_out, o_mem_command_oe};
    ////////////////////////////////////////////////////////////////
    always_ff @(posedge i_mem_clk or negedge i_arst_n) begin
        if (!i_arst_n) pins_at_rise <= 4'h0;
        else pins_at_rise <= pins;
    end
    always_ff @(negedge i_mem_clk or negedge i_arst_n) begin
        if (!i_arst_n) sel_run <= 5'h00;
        else sel_run <= o_mem_select ? sel_run + 5'h01 : 5'h00;
    end
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) regs_prev <= '0;
        else regs_prev <= o_gamma_regs;
    end
    always_comb begin
        for (int r = 0; r < REGS; r++) begin
            reg_changed[r] = |(o_gamma_regs[r*DW+:DW] ^ regs_prev[r*DW+:DW]);
        end
    end
    ////////////////////////////////////////////////////////////////
    AST_PINS_ON_FALL: assert property (
        @(negedge i_mem_clk) disable iff (!i_arst_n) pins == pins_at_rise)
        else $error("memory pins moved off a falling edge");
    AST_CMD_HEAD: assert property (
        @(negedge i_mem_clk) disable iff (!i_arst_n) $rose(o_mem_select) |->
        (o_mem_command_out ##1 o_mem_command_out ##1 !o_mem_command_out) or (##[1:3] !o_mem_select))
        else $error("bad start bit or opcode");
    AST_FETCH_LEN: assert property (
        @(negedge i_mem_clk) disable iff (!i_arst_n) $fell(o_mem_select) && o_mem_select_oe
        |-> sel_run inside {5'h19, 5'h1A})
        else $error("select length wrong");
    AST_BACK_TO_BACK: assert property (
        @(negedge i_mem_clk) disable iff (!i_arst_n) $fell(o_mem_select) && o_mem_select_oe
        |-> ##1 !o_mem_select ##[1:40] (o_mem_select || !o_mem_select_oe))
        else $error("no next fetch");
    AST_RELEASE: assert property (
        @(negedge i_mem_clk) disable iff (!i_arst_n) i_hold [*3] |=>
        !o_mem_select_oe && !o_mem_command_oe && !o_mem_select && !o_mem_command_out)
        else $error("pins not released under hold");
    AST_RESUME: assert property (
        @(negedge i_mem_clk) disable iff (!i_arst_n) !i_hold [*4] |=>
        o_mem_select_oe && o_mem_command_oe)
        else $error("pins not driven with hold low");
    AST_OE_PAIR: assert property (
        @(negedge i_mem_clk) disable iff (!i_arst_n) o_mem_select_oe == o_mem_command_oe)
        else $error("enables disagree");
    AST_ONE_LOAD: assert property (
        @(posedge i_core_clk) disable iff (!i_arst_n) $countones(reg_changed) <= 1)
        else $error("several gamma registers changed at once");
    AST_RESET_CLEAR: assert property (
        @(posedge i_core_clk) !i_arst_n |-> o_gamma_regs == '0 && !o_mem_select_oe)
        else $error("reset did not clear");
    COV_FETCH: cover property (@(negedge i_mem_clk) disable iff (!i_arst_n)
        $fell(o_mem_select) && o_mem_select_oe);
    COV_RELEASE: cover property (@(negedge i_mem_clk) disable iff (!i_arst_n) $fell(o_mem_select_oe));
    COV_LOAD: cover property (@(posedge i_core_clk) disable iff (!i_arst_n) |reg_changed);
endmodule : serial_eeprom_autoread_assertions
bind serial_eeprom_autoread serial_eeprom_autoread_assertions #(.REGS(REGS)) u_assert (
    .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_mem_clk(i_mem_clk), .i_hold(i_hold),
    .o_mem_select(o_mem_select), .o_mem_select_oe(o_mem_select_oe),
    .o_mem_command_out(o_mem_command_out), .o_mem_command_oe(o_mem_command_oe),
    .o_gamma_regs(o_gamma_regs)
);
`default_nettype wire

/* tb/mem_model.sv */
// behavioural three-wire serial configuration memory
`timescale 1ns/1ps
`default_nettype none
module mem_model (
    input  wire logic i_clk,
    input  wire logic i_sel,
    input  wire logic i_cmd,
    output logic      o_data
);
    logic [15:0] words [0:63];
    logic [21:0] done_q [$];
    logic [8:0]  cmd;
    logic [5:0]  addr;
    int          cnt;
    int          bad;
    initial begin
        o_data = 1'h0;
        cnt = 0;
        bad = 0;
    end
    always @(posedge i_clk) begin
        if (!i_sel) begin
            cnt = 0;
            o_data <= ~o_data; // released output is not held
        end else if (cnt < 9) begin
            cmd = {cmd[7:0], i_cmd};
            cnt++;
            if (cnt == 9) begin
                bad += int'(cmd[8:6] !== 3'h6);
                addr = cmd[5:0];
                o_data <= 1'h0;
            end
        end else if (cnt < 25) begin
            o_data <= words[addr][24-cnt];
            cnt++;
            if (cnt == 25) done_q.push_back({addr, words[addr]});
        end else begin
            o_data <= ~o_data;
        end
    end
endmodule : mem_model
`default_nettype wire

/* tb/test_serial_eeprom_autoread.sv */
// self-checking bench for the serial memory auto-read engine
`timescale 1ns/1ps
`default_nettype none
module test_serial_eeprom_autoread;
    localparam int GW = autoread_pkg::REG_COUNT * autoread_pkg::DAC_BITS;
    logic          i_core_clk, i_mem_clk, i_arst_n, i_hold, i_refresh_external;
    logic          sel, sel_oe, cmd, cmd_oe, mem_do, refresh, exp_ref;
    logic [GW-1:0] gamma, exp_vec;
    logic [21:0]   fw;
    int            num_errors, checks, nfetch, exp_next, seed;
    bit            mon_on;
    serial_eeprom_autoread dut (
        .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_mem_clk(i_mem_clk), .i_hold(i_hold),
        .i_mem_word_in(mem_do), .i_refresh_external(i_refresh_external),
        .o_mem_select(sel), .o_mem_select_oe(sel_oe), .o_mem_command_out(cmd),
        .o_mem_command_oe(cmd_oe), .o_gamma_regs(gamma), .o_refresh_source_select(refresh)
    );
    mem_model u_mem (.i_clk(i_mem_clk), .i_sel(sel_oe & sel), .i_cmd(cmd_oe & cmd), .o_data(mem_do));
    ////////////////////////////////////////////////////////////////
    task automatic cmp_vec(input logic [GW-1:0] got, input logic [GW-1:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask : cmp_vec
    task automatic cmp_bit(input logic got, input logic exp, input string what);
        cmp_vec(GW'(got), GW'(exp), what);
    endtask : cmp_bit
    task automatic cmp_int(input int got, input int exp, input string what);
        cmp_vec(GW'(got), GW'(exp), what);
    endtask : cmp_int
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop
    task automatic drive(input logic hold, input logic ext);
        @(posedge i_core_clk);
        #1;
        i_hold = hold;
        i_refresh_external = ext;
    endtask : drive
    task automatic fill;
        for (int a = 0; a < 64; a++) begin
            u_mem.words[a] = {1'($urandom), a[4:0], 10'($urandom)};
        end
    endtask : fill
    task automatic do_reset;
        mon_on = 0;
        repeat (200) @(posedge i_core_clk);
        #1 i_arst_n = 1'h0;
        repeat (20) @(posedge i_core_clk);
        #1;
        cmp_vec(gamma, '0, "gamma not cleared");
        cmp_bit(refresh | sel_oe | cmd_oe, 1'h0, "outputs not cleared");
        i_arst_n = 1'h1;
        exp_vec = '0;
        exp_next = 0;
        u_mem.done_q.delete();
        mon_on = 1;
    endtask : do_reset
    task automatic wait_fetches(input int n);
        int target;
        target = nfetch + n;
        for (int i = 0; i < 100000 && nfetch < target; i++) @(posedge i_core_clk);
    endtask : wait_fetches
    ////////////////////////////////////////////////////////////////
    initial begin
        i_core_clk = 1'h0;
        forever #4 i_core_clk = ~i_core_clk;
    end
    initial begin
        i_mem_clk = 1'h1;
        #3.3;
        forever #15 i_mem_clk = ~i_mem_clk;
    end
    initial begin
        #300us;
        num_errors++;
        $display("MISMATCH %0t watchdog expired", $time);
        report_and_stop();
    end
    initial begin
        forever begin
            @(posedge i_core_clk);
            if (mon_on && u_mem.done_q.size() > 0) begin
                fw = u_mem.done_q.pop_front();
                exp_ref = i_refresh_external;
                cmp_int(int'(fw[21:16]), exp_next, "fetch address");
                exp_next = (exp_next + 1) % autoread_pkg::REG_COUNT;
                exp_vec[int'(fw[14:10])*10+:10] = fw[9:0];
                nfetch++;
                repeat (60) @(posedge i_core_clk);
                #1;
                if (mon_on) begin
                    cmp_vec(gamma, exp_vec, "gamma registers");
                    cmp_bit(refresh, exp_ref, "refresh source");
                end
            end
        end
    end
    initial begin
        i_arst_n = 1'h1;
        i_hold = 1'h0;
        i_refresh_external = 1'h0;
        num_errors = 0;
        checks = 0;
        nfetch = 0;
        #1 i_arst_n = 1'h0;
        seed = $urandom(2);
        fill();
        do_reset();
        drive(1'h0, 1'($urandom));
        wait_fetches(21);
        repeat ($urandom_range(150, 10)) @(posedge i_core_clk);
        drive(1'h1, i_refresh_external);
        repeat (40) @(posedge i_core_clk);
        cmp_bit(sel_oe | cmd_oe, 1'h0, "pins not released");
        fill();
        drive(1'h1, ~i_refresh_external);
        drive(1'h0, i_refresh_external);
        wait_fetches(21);
        do_reset();
        wait_fetches(3);
        cmp_int(u_mem.bad, 0, "read command");
        report_and_stop();
    end
endmodule : test_serial_eeprom_autoread
`default_nettype wire
